// ==== hdl/assr_pkg.sv ====
// package for the serial status and interrupt block
// assumes a 32-bit axi4-lite register bus and a single clock domain
package assr_pkg;
   // register byte offsets
   localparam logic [7:0]  ADDR_STATUS = 8'h00;
   localparam logic [7:0]  ADDR_CTRLA  = 8'h04;
   localparam logic [7:0]  ADDR_IRQ_ST = 8'h08;
   localparam logic [7:0]  ADDR_IRQ_MK = 8'h0C;
   localparam logic [7:0]  ADDR_EVENT  = 8'h10;
   localparam logic [7:0]  ADDR_TXHOLD = 8'h14;
   // status register fields
   localparam int          BIT_FE      = 4;
   localparam int          BIT_RIE     = 3;
   localparam int          BIT_SEL     = 2;
   localparam int          BIT_TDE     = 1;
   localparam int          BIT_TIE     = 0;
   // control a field: error flag clear, write 0 to clear
   localparam int          BIT_EFC     = 3;
   // event register fields (software-visible receive flags)
   localparam int          BIT_RDF     = 0;
   localparam int          BIT_OVR     = 1;
   localparam int          BIT_PAR     = 2;
   // irq status fields
   localparam int          IRQ_RX      = 0;
   localparam int          IRQ_TX      = 1;
   localparam int          IRQ_W       = 2;
   localparam logic [7:0]  STATUS_RST  = 8'h02;
   localparam logic [7:0]  CTRLA_RST   = 8'h08;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : assr_pkg

// ==== hdl/assr_sync_if.sv ====
// interface carrying synchronised line-side levels between modules
// assumes producer and consumer share ref_clk_i
`timescale 1ns/100ps
interface assr_sync_if;
   logic cts;
   logic dcd;
   logic shared_pin;
   modport src (output cts, output dcd, output shared_pin);
   modport dst (input cts, input dcd, input shared_pin);
endinterface : assr_sync_if

// ==== hdl/assr_sync2.sv ====
// two flip-flop synchroniser for one asynchronous level
// assumes input is a pin outside the ref_clk_i domain
`timescale 1ns/100ps
module assr_sync2 (
   // clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   // level in and out
   input  wire logic async_i,
   output logic      sync_o
);
   logic meta;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         meta   <= 1'b0;
         sync_o <= 1'b0;
      end else begin
         meta   <= async_i;
         sync_o <= meta;
      end
   end
endmodule : assr_sync2

// ==== hdl/assr_top.sv ====
// status and interrupt control of one async serial channel, axi4-lite slave
// assumes receiver and transmitter datapaths feed one-cycle pulses on ref_clk_i
// Behaviour
// - bad stop bit sets framing error
// - clear framing error: efc=0, carrier, stop, reset
// - rx enable requests on any rx flag
// - channel 0: carrier rising edge requests too
// - select bit enables the cts input and holds rx high, else passes shared pin to rx
// - holding write clears empty; shift load sets
// - stop mode and reset force empty
// - high clear-to-send holds empty low while select bit is set
// - tx enable requests while empty
// - reset clears tx interrupt enable
//
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module assr_top #(
   parameter bit IS_CH0 = 1'b1
) (
   // clock and reset
   input  wire logic        ref_clk_i,
   input  wire logic        rst_i,
   // axi4-lite write address
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [7:0]  s_axi_awaddr,
   // axi4-lite write data
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   // axi4-lite write response
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   output logic [1:0]       s_axi_bresp,
   // axi4-lite read
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   input  wire logic [7:0]  s_axi_araddr,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   // datapath events, one-cycle pulses; stop bit and stop mode are levels
   input  wire logic        rx_frame_done_i,
   input  wire logic        rx_stop_bit_i,
   input  wire logic        rx_data_full_i,
   input  wire logic        rx_overrun_i,
   input  wire logic        rx_parity_err_i,
   input  wire logic        rx_data_read_i,
   input  wire logic        tx_shift_load_i,
   input  wire logic        peripheral_stop_mode_i,
   // line-side pins
   input  wire logic        ch1_clear_to_send_input_i,
   input  wire logic        carrier_detect_input_i,
   input  wire logic        shared_pin_i,
   // outputs
   output logic             clocked_serial_rx_pin_o,
   output logic             tx_holding_write_o,
   output logic [7:0]       tx_holding_data_o,
   output logic             rx_irq_req_o,
   output logic             tx_irq_req_o,
   output logic             irq_o
);
   localparam int IRQ_W = assr_pkg::IRQ_W;

   assr_sync_if sync_bus ();

   assr_sync2 u_sync_cts (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (ch1_clear_to_send_input_i),
      .sync_o    (sync_bus.cts)
   );
   assr_sync2 u_sync_dcd (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (carrier_detect_input_i),
      .sync_o    (sync_bus.dcd)
   );
   assr_sync2 u_sync_pin (
      .ref_clk_i (ref_clk_i),
      .rst_i     (rst_i),
      .async_i   (shared_pin_i),
      .sync_o    (sync_bus.shared_pin)
   );

   logic              framing_error_flag;
   logic              rx_irq_enable;
   logic              ch1_handshake_pin_select;
   logic              tx_empty_raw;
   logic              tx_holding_empty_flag;
   logic              tx_irq_enable;
   logic              error_flag_clear_bit;
   logic              rx_data_full_flag;
   logic              rx_overrun_flag;
   logic              parity_error_flag;
   logic              dcd_prev;
   logic              dcd_rise_pend;
   logic [IRQ_W-1:0]  irq_status;
   logic [IRQ_W-1:0]  irq_mask;
   logic              cts_eff;
   logic              dcd_rise;
   logic              wr_fire;
   logic              rd_fire;
   logic              aw_held;
   logic              w_held;
   logic [7:0]        aw_addr;
   logic [31:0]       w_data;
   logic [3:0]        w_strb;
   logic [7:0]        next_status;
   logic [31:0]       next_rdata;
   logic              rd_hit;
   logic              wr_hit;

   assign cts_eff                 = ch1_handshake_pin_select & sync_bus.cts;
   assign clocked_serial_rx_pin_o = ch1_handshake_pin_select ? 1'b1 : sync_bus.shared_pin;

   assign tx_holding_empty_flag = tx_empty_raw & ~cts_eff;

   // write channel capture; address and data in either order
   assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
   assign s_axi_wready  = ~w_held & ~s_axi_bvalid;
   assign wr_fire       = aw_held & w_held & ~s_axi_bvalid;
   assign wr_hit        = (aw_addr == assr_pkg::ADDR_STATUS) || (aw_addr == assr_pkg::ADDR_CTRLA)
                        || (aw_addr == assr_pkg::ADDR_IRQ_ST) || (aw_addr == assr_pkg::ADDR_IRQ_MK)
                        || (aw_addr == assr_pkg::ADDR_TXHOLD);

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_held      <= 1'b0;
         w_held       <= 1'b0;
         aw_addr      <= 8'h00;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= assr_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? assr_pkg::RESP_OKAY : assr_pkg::RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // writes only take effect when the low byte lane is enabled
   function automatic logic wr_to(input logic [7:0] a);
      wr_to = wr_fire && (aw_addr == a) && w_strb[0];
   endfunction : wr_to

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_irq_enable            <= assr_pkg::STATUS_RST[assr_pkg::BIT_RIE];
         ch1_handshake_pin_select <= assr_pkg::STATUS_RST[assr_pkg::BIT_SEL];
         tx_irq_enable            <= assr_pkg::STATUS_RST[assr_pkg::BIT_TIE];
         error_flag_clear_bit     <= assr_pkg::CTRLA_RST[assr_pkg::BIT_EFC];
         irq_mask                 <= '0;
      end else begin
         if (wr_to(assr_pkg::ADDR_STATUS)) begin
            rx_irq_enable            <= w_data[assr_pkg::BIT_RIE];
            ch1_handshake_pin_select <= w_data[assr_pkg::BIT_SEL];
            tx_irq_enable            <= w_data[assr_pkg::BIT_TIE];
         end
         if (wr_to(assr_pkg::ADDR_CTRLA)) begin
            error_flag_clear_bit <= w_data[assr_pkg::BIT_EFC];
         end
         if (wr_to(assr_pkg::ADDR_IRQ_MK)) begin
            irq_mask <= w_data[IRQ_W-1:0];
         end
      end
   end

   // framing error: set wins over the software clear, line and stop clears dominate
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         framing_error_flag <= 1'b0;
      end else if (sync_bus.dcd || peripheral_stop_mode_i) begin
         framing_error_flag <= 1'b0;
      end else if (rx_frame_done_i && !rx_stop_bit_i) begin
         framing_error_flag <= 1'b1;
      end else if (wr_to(assr_pkg::ADDR_CTRLA) && !w_data[assr_pkg::BIT_EFC]) begin
         framing_error_flag <= 1'b0;
      end
   end

   // other receive flags; error clear also drops overrun and parity
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         rx_data_full_flag <= 1'b0;
         rx_overrun_flag   <= 1'b0;
         parity_error_flag <= 1'b0;
      end else if (peripheral_stop_mode_i) begin
         rx_data_full_flag <= 1'b0;
         rx_overrun_flag   <= 1'b0;
         parity_error_flag <= 1'b0;
      end else begin
         if (rx_data_full_i) begin
            rx_data_full_flag <= 1'b1;
         end else if (rx_data_read_i) begin
            rx_data_full_flag <= 1'b0;
         end
         if (rx_overrun_i) begin
            rx_overrun_flag <= 1'b1;
         end else if (wr_to(assr_pkg::ADDR_CTRLA) && !w_data[assr_pkg::BIT_EFC]) begin
            rx_overrun_flag <= 1'b0;
         end
         if (rx_parity_err_i) begin
            parity_error_flag <= 1'b1;
         end else if (wr_to(assr_pkg::ADDR_CTRLA) && !w_data[assr_pkg::BIT_EFC]) begin
            parity_error_flag <= 1'b0;
         end
      end
   end

   // holding register empty and hand-off to the transmitter
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         tx_empty_raw       <= 1'b1;
         tx_holding_write_o <= 1'b0;
         tx_holding_data_o  <= 8'h00;
      end else begin
         tx_holding_write_o <= 1'b0;
         if (peripheral_stop_mode_i) begin
            tx_empty_raw <= 1'b1;
         end else if (wr_to(assr_pkg::ADDR_TXHOLD)) begin
            tx_empty_raw       <= 1'b0;
            tx_holding_write_o <= 1'b1;
            tx_holding_data_o  <= w_data[7:0];
         end else if (tx_shift_load_i) begin
            tx_empty_raw <= 1'b1;
         end
      end
   end

   // carrier rising edge, kept pending until the enable is off or a data read
   assign dcd_rise = IS_CH0 & sync_bus.dcd & ~dcd_prev;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dcd_prev      <= 1'b0;
         dcd_rise_pend <= 1'b0;
      end else begin
         dcd_prev <= sync_bus.dcd;
         if (dcd_rise && rx_irq_enable) begin
            dcd_rise_pend <= 1'b1;
         end else if (!rx_irq_enable || rx_data_read_i) begin
            dcd_rise_pend <= 1'b0;
         end
      end
   end

   assign rx_irq_req_o = rx_irq_enable & (rx_data_full_flag | rx_overrun_flag
                       | parity_error_flag | framing_error_flag | dcd_rise_pend);
   assign tx_irq_req_o = tx_irq_enable & tx_holding_empty_flag;

   // sticky status: set on request rise, write one to clear, set wins
   logic [IRQ_W-1:0] req_prev;
   logic [IRQ_W-1:0] req_now;
   logic [IRQ_W-1:0] clr_bits;
   assign req_now  = {tx_irq_req_o, rx_irq_req_o};
   assign clr_bits = wr_to(assr_pkg::ADDR_IRQ_ST) ? w_data[IRQ_W-1:0] : '0;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_prev   <= '0;
         irq_status <= '0;
      end else begin
         req_prev   <= req_now;
         irq_status <= (irq_status & ~clr_bits) | (req_now & ~req_prev);
      end
   end
   assign irq_o = |(irq_status & irq_mask);

   // read channel
   always_comb begin
      next_status = 8'h00;
      next_status[assr_pkg::BIT_FE]  = framing_error_flag;
      next_status[assr_pkg::BIT_RIE] = rx_irq_enable;
      next_status[assr_pkg::BIT_SEL] = ch1_handshake_pin_select;
      next_status[assr_pkg::BIT_TDE] = tx_holding_empty_flag;
      next_status[assr_pkg::BIT_TIE] = tx_irq_enable;
      next_rdata = 32'h0000_0000;
      rd_hit     = 1'b1;
      unique case (s_axi_araddr)
         assr_pkg::ADDR_STATUS: next_rdata[7:0] = next_status;
         assr_pkg::ADDR_CTRLA:  next_rdata[assr_pkg::BIT_EFC] = error_flag_clear_bit;
         assr_pkg::ADDR_IRQ_ST: next_rdata[IRQ_W-1:0] = irq_status;
         assr_pkg::ADDR_IRQ_MK: next_rdata[IRQ_W-1:0] = irq_mask;
         assr_pkg::ADDR_EVENT: begin
            next_rdata[assr_pkg::BIT_RDF] = rx_data_full_flag;
            next_rdata[assr_pkg::BIT_OVR] = rx_overrun_flag;
            next_rdata[assr_pkg::BIT_PAR] = parity_error_flag;
         end
         assr_pkg::ADDR_TXHOLD: next_rdata[7:0] = tx_holding_data_o;
         default:               rd_hit = 1'b0;
      endcase
   end

   assign s_axi_arready = ~s_axi_rvalid;
   assign rd_fire       = s_axi_arvalid & s_axi_arready;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= assr_pkg::RESP_OKAY;
      end else if (rd_fire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= rd_hit ? assr_pkg::RESP_OKAY : assr_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule : assr_top

// ==== tb/assr_remote.sv ====
// line-side model of the remote serial device
// assumes the bench commands each level; edges land off the clock grid
`timescale 1ns/100ps
module assr_remote (
   // levels commanded by the bench
   input  wire logic cts_i,
   input  wire logic dcd_i,
   input  wire logic rxd_i,
   // modem and data lines to the block
   output wire logic cts_o,
   output wire logic dcd_o,
   output wire logic rxd_o
);
   // remote timebase is unrelated, so skew by part of a cycle
   assign #3 cts_o = cts_i;
   assign #3 dcd_o = dcd_i;
   assign #3 rxd_o = rxd_i;
endmodule : assr_remote

// ==== tb/assr_top_asserts.sv ====
// port assertions for the serial status and interrupt block
// assumes one clock domain and an async active-high reset
`timescale 1ns/100ps
module assr_top_asserts (
   // clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_i,
   // causes at the inputs
   input wire logic s_axi_wvalid,
   input wire logic s_axi_awvalid,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic rx_frame_done_i,
   input wire logic rx_stop_bit_i,
   input wire logic rx_data_full_i,
   input wire logic rx_overrun_i,
   input wire logic rx_parity_err_i,
   input wire logic rx_data_read_i,
   input wire logic tx_shift_load_i,
   input wire logic peripheral_stop_mode_i,
   input wire logic ch1_clear_to_send_input_i,
   input wire logic carrier_detect_input_i,
   input wire logic shared_pin_i,
   // effects at the outputs
   input wire logic clocked_serial_rx_pin_o,
   input wire logic tx_holding_write_o,
   input wire logic rx_irq_req_o,
   input wire logic tx_irq_req_o,
   input wire logic irq_o
);
   // histories span the synchroniser latency with margin
   logic [5:0] dcd_h;
   logic [5:0] cts_h;
   logic [3:0] pin_h;
   // recent status writes may change the enables
   logic [2:0] stw_h;
   wire logic  rx_ev;
   wire logic  cts_q;
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         dcd_h <= 6'h00;
         cts_h <= 6'h00;
         pin_h <= 4'h0;
         stw_h <= 3'h0;
      end else begin
         stw_h <= {stw_h[1:0], s_axi_awvalid && (s_axi_awaddr == assr_pkg::ADDR_STATUS)};
         dcd_h <= {dcd_h[4:0], carrier_detect_input_i};
         cts_h <= {cts_h[4:0], ch1_clear_to_send_input_i};
         pin_h <= {pin_h[2:0], shared_pin_i};
      end
   end
   assign rx_ev = (rx_frame_done_i & ~rx_stop_bit_i) | rx_data_full_i
                | rx_overrun_i | rx_parity_err_i;
   assign cts_q = ~ch1_clear_to_send_input_i & (cts_h == 6'h00);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   a_tie_reset: assert property ($fell(rst_i) |-> !tx_irq_req_o && !rx_irq_req_o)
      else $error("request high after reset");
   a_wr_clears: assert property (tx_holding_write_o && !peripheral_stop_mode_i
      && !$past(peripheral_stop_mode_i) && !$past(tx_shift_load_i) |-> !tx_irq_req_o)
      else $error("holding write left tx request");
   a_stop_forces: assert property (peripheral_stop_mode_i && $past(peripheral_stop_mode_i)
      && $past(tx_irq_req_o) && cts_q && stw_h == 3'h0 |-> tx_irq_req_o)
      else $error("empty cleared in stop");
   a_tx_level: assert property (tx_irq_req_o && !s_axi_wvalid && !$past(s_axi_wvalid)
      && !peripheral_stop_mode_i && !$past(peripheral_stop_mode_i) && cts_q
      |=> tx_irq_req_o)
      else $error("tx request dropped");
   a_rx_level: assert property (rx_irq_req_o && !s_axi_wvalid && !$past(s_axi_wvalid)
      && !rx_data_read_i && !peripheral_stop_mode_i && !carrier_detect_input_i
      && dcd_h == 6'h00 |=> rx_irq_req_o || peripheral_stop_mode_i)
      else $error("rx request dropped");
   a_rx_cause: assert property ($rose(rx_irq_req_o) |-> $past(rx_ev)
      || $past(s_axi_wvalid, 2) || dcd_h != 6'h00)
      else $error("rx request without cause");
   a_tx_cause: assert property ($rose(tx_irq_req_o) |-> $past(tx_shift_load_i)
      || $past(s_axi_wvalid, 2) || peripheral_stop_mode_i
      || $past(peripheral_stop_mode_i) || cts_h != 6'h00)
      else $error("tx request without cause");
   a_irq_cause: assert property ($rose(irq_o) |-> $past(rx_irq_req_o) || $past(tx_irq_req_o)
      || $past(s_axi_wvalid, 2))
      else $error("irq without request");
   a_pin_route: assert property (!clocked_serial_rx_pin_o |-> pin_h != 4'hF)
      else $error("rx pin low while pin high");
endmodule : assr_top_asserts

bind assr_top assr_top_asserts u_chk (
   .ref_clk_i, .rst_i, .s_axi_wvalid, .s_axi_awvalid, .s_axi_awaddr,
   .rx_frame_done_i, .rx_stop_bit_i,
   .rx_data_full_i, .rx_overrun_i, .rx_parity_err_i, .rx_data_read_i,
   .tx_shift_load_i, .peripheral_stop_mode_i, .ch1_clear_to_send_input_i,
   .carrier_detect_input_i, .shared_pin_i, .clocked_serial_rx_pin_o,
   .tx_holding_write_o, .rx_irq_req_o, .tx_irq_req_o, .irq_o);

// ==== tb/tb.sv ====
// self-checking bench for the serial status and interrupt block
// assumes the remote line model and the bound checker are compiled first
`timescale 1ns/100ps
module tb;
   logic        clk;
   logic        rst;
   logic        awv, wv, bry, arv, rry, stb, stp, cts, dcd, sp;
   logic [7:0]  awa, ara;
   logic [31:0] wd, v;
   logic [5:0]  ev;
   logic [1:0]  r;
   logic [3:0]  ws;
   wire logic   awr, wrd, bv, arr, rv, prx, hw, rxq, txq, irq, cts_p, dcd_p, sp_p;
   wire logic [1:0]  br, rr;
   wire logic [31:0] rdt;
   wire logic [7:0]  hd;
   int          failures, tests_run;
   int          hw_n = 0;

   assr_remote rem (.cts_i(cts), .dcd_i(dcd), .rxd_i(sp), .cts_o(cts_p), .dcd_o(dcd_p),
      .rxd_o(sp_p));
   assr_top dut (.ref_clk_i(clk), .rst_i(rst), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_awaddr(awa), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_bresp(br),
      .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara), .s_axi_rvalid(rv),
      .s_axi_rready(rry), .s_axi_rdata(rdt), .s_axi_rresp(rr),
      .rx_frame_done_i(ev[0]), .rx_stop_bit_i(stb), .rx_data_full_i(ev[1]),
      .rx_overrun_i(ev[2]), .rx_parity_err_i(ev[3]), .rx_data_read_i(ev[4]),
      .tx_shift_load_i(ev[5]), .peripheral_stop_mode_i(stp),
      .ch1_clear_to_send_input_i(cts_p), .carrier_detect_input_i(dcd_p),
      .shared_pin_i(sp_p), .clocked_serial_rx_pin_o(prx), .tx_holding_write_o(hw),
      .tx_holding_data_o(hd), .rx_irq_req_o(rxq), .tx_irq_req_o(txq), .irq_o(irq));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // count holding-register hand-offs seen by the transmitter
   always @(posedge clk) begin
      if (hw === 1'b1) begin
         hw_n <= hw_n + 1;
      end
   end

   task chk(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   // ready is read at the falling edge so the handshake edge is never raced
   task wr(input logic [7:0] a, input logic [31:0] d);
      logic ta, tw, da, dw;
      ta = 1'b0;
      tw = 1'b0;
      @(posedge clk);
      awv <= 1'b1;
      awa <= a;
      wv <= 1'b1;
      wd <= d;
      bry <= 1'b1;
      while (!(ta && tw)) begin
         @(negedge clk);
         da = awv && awr;
         dw = wv && wrd;
         @(posedge clk);
         ta = ta | da;
         tw = tw | dw;
         if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
      end
      do @(negedge clk); while (bv !== 1'b1);
      r = br;
      @(posedge clk);
      bry <= 1'b0;
   endtask : wr

   task rd(input logic [7:0] a);
      @(posedge clk);
      arv <= 1'b1;
      ara <= a;
      rry <= 1'b1;
      do @(negedge clk); while (arr !== 1'b1);
      @(posedge clk);
      arv <= 1'b0;
      do @(negedge clk); while (rv !== 1'b1);
      v = rdt;
      r = rr;
      @(posedge clk);
      rry <= 1'b0;
   endtask : rd

   task pls(input int k, input logic s);
      @(posedge clk);
      stb <= s;
      ev[k] <= 1'b1;
      @(posedge clk);
      ev[k] <= 1'b0;
      @(negedge clk);
   endtask : pls

   task idle(input int n);
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask : idle

   task tend(input string n);
      $display("test %s done", n);
   endtask : tend

   task end_of_test;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : end_of_test

   // tests need about 200 cycles; 100 us leaves wide margin
   initial begin
      #100000;
      failures++;
      end_of_test;
   end

   initial begin
      {awv, wv, bry, arv, rry, stp, cts, dcd, sp} = '0;
      awa = 8'h00;
      ara = 8'h00;
      wd = 32'h00000000;
      ev = 6'h00;
      stb = 1'b1;
      ws = 4'hF;
      rst = 1'b1;
      failures = 0;
      tests_run = 0;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      rd(assr_pkg::ADDR_STATUS);
      chk("status reset", 32'h00000002, v);
      chk("tx req reset", 32'h00000000, 32'(txq));
      rd(assr_pkg::ADDR_CTRLA);
      chk("ctrla reset", 32'h00000008, v);
      rd(8'h1C);
      chk("unmapped resp", 32'(assr_pkg::RESP_SLVERR), 32'(r));
      wr(8'h1C, 32'h000000FF);
      chk("unmapped wresp", 32'(assr_pkg::RESP_SLVERR), 32'(r));
      ws <= 4'hE;
      wr(assr_pkg::ADDR_STATUS, 32'h0000000D);
      ws <= 4'hF;
      rd(assr_pkg::ADDR_STATUS);
      chk("strobe off", 32'h00000002, v);
      tend("reset");
      pls(0, 1'b1);
      rd(assr_pkg::ADDR_STATUS);
      chk("good stop", 32'h00000002, v);
      pls(0, 1'b0);
      rd(assr_pkg::ADDR_STATUS);
      chk("bad stop", 32'h00000012, v);
      chk("rx req off", 32'h00000000, 32'(rxq));
      wr(assr_pkg::ADDR_STATUS, 32'h00000008);
      chk("rx req on", 32'h00000001, 32'(rxq));
      wr(assr_pkg::ADDR_CTRLA, 32'h00000000);
      chk("efc drop", 32'h00000000, 32'(rxq));
      wr(assr_pkg::ADDR_CTRLA, 32'h00000008);
      pls(0, 1'b0);
      @(posedge clk);
      dcd <= 1'b1;
      idle(6);
      rd(assr_pkg::ADDR_STATUS);
      chk("carrier clear", 32'h0000000A, v);
      chk("carrier edge", 32'h00000001, 32'(rxq));
      pls(4, 1'b1);
      chk("edge cleared", 32'h00000000, 32'(rxq));
      @(posedge clk);
      dcd <= 1'b0;
      idle(6);
      pls(0, 1'b0);
      @(posedge clk);
      stp <= 1'b1;
      idle(2);
      rd(assr_pkg::ADDR_STATUS);
      chk("stop status", 32'h0000000A, v);
      @(posedge clk);
      stp <= 1'b0;
      tend("framing");
      for (int k = 1; k < 4; k++) begin
         pls(k, 1'b1);
         chk("rx flag req", 32'h00000001, 32'(rxq));
         if (k == 1)
            pls(4, 1'b1);
         else begin
            wr(assr_pkg::ADDR_CTRLA, 32'h00000000);
            wr(assr_pkg::ADDR_CTRLA, 32'h00000008);
         end
         chk("rx flag drop", 32'h00000000, 32'(rxq));
      end
      tend("rx flags");
      wr(assr_pkg::ADDR_STATUS, 32'h00000001);
      chk("tx req empty", 32'h00000001, 32'(txq));
      wr(assr_pkg::ADDR_TXHOLD, 32'h000000A5);
      chk("hold data", 32'h000000A5, 32'(hd));
      chk("tx req full", 32'h00000000, 32'(txq));
      rd(assr_pkg::ADDR_STATUS);
      chk("status full", 32'h00000001, v);
      chk("hold pulses", 32'h00000001, 32'(hw_n));
      pls(5, 1'b1);
      chk("tx req load", 32'h00000001, 32'(txq));
      wr(assr_pkg::ADDR_TXHOLD, 32'h0000005A);
      @(posedge clk);
      stp <= 1'b1;
      idle(2);
      chk("stop empty", 32'h00000001, 32'(txq));
      wr(assr_pkg::ADDR_TXHOLD, 32'h0000003C);
      chk("stop write", 32'h00000001, 32'(txq));
      @(posedge clk);
      stp <= 1'b0;
      pls(5, 1'b1);
      chk("stop pulses", 32'h00000002, 32'(hw_n));
      wr(assr_pkg::ADDR_STATUS, 32'h00000005);
      @(posedge clk);
      cts <= 1'b1;
      idle(6);
      rd(assr_pkg::ADDR_STATUS);
      chk("cts status", 32'h00000005, v);
      chk("cts tx req", 32'h00000000, 32'(txq));
      chk("pin as cts", 32'h00000001, 32'(prx));
      @(posedge clk);
      cts <= 1'b0;
      idle(6);
      chk("cts low req", 32'h00000001, 32'(txq));
      wr(assr_pkg::ADDR_STATUS, 32'h00000001);
      idle(2);
      chk("pin as rx 0", 32'h00000000, 32'(prx));
      @(posedge clk);
      sp <= 1'b1;
      idle(6);
      chk("pin as rx 1", 32'h00000001, 32'(prx));
      tend("transmit");
      wr(assr_pkg::ADDR_IRQ_MK, 32'h00000000);
      wr(assr_pkg::ADDR_IRQ_ST, 32'h00000003);
      wr(assr_pkg::ADDR_TXHOLD, 32'h00000011);
      pls(5, 1'b1);
      rd(assr_pkg::ADDR_IRQ_ST);
      chk("irq sticky", 32'h00000002, v);
      chk("irq masked", 32'h00000000, 32'(irq));
      wr(assr_pkg::ADDR_IRQ_MK, 32'h00000002);
      chk("irq unmasked", 32'h00000001, 32'(irq));
      wr(assr_pkg::ADDR_IRQ_ST, 32'h00000002);
      chk("irq cleared", 32'h00000000, 32'(irq));
      rd(assr_pkg::ADDR_IRQ_ST);
      chk("irq st clear", 32'h00000000, v);
      tend("interrupt");
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rd(assr_pkg::ADDR_STATUS);
      chk("status rereset", 32'h00000002, v);
      chk("tx req rereset", 32'h00000000, 32'(txq));
      tend("second reset");
      end_of_test;
   end
endmodule : tb
